// *** hdl/sram_load_ctrl.sv ***
// SRAM loader control register, data port gating and processor fetch.
`timescale 1ns/1ps
// Contract
// R1: Control register is command 60h, one byte, readable and writable.
// R2: Bit 7 set permits host SRAM access; clear blocks it.
// R3: Bit 6 set holds the internal processor in reset.
// R4: Core hold resets only the processor, never host-visible registers.
// R5: Bit 5 is reserved, read/write, resets to zero.
// R6: Bit 4 set enables SRAM parity checking; clear disables it.
// R7: Host should enable parity whenever SRAM code is used.
// R8: Bit 3 set lets the processor fetch from SRAM and ROM.
// R9: Host must set bit 3 after loading the SRAM image.
// R10: Bit 2 with direction routes data-port accesses to parity bits.
// R11: Direction 0: each host write to 61h stores a byte.
// R12: Direction 1: each host read of 61h returns SRAM content.
// R13: Writing 1 to bit 0 returns the SRAM pointer to the start.
module sram_load_ctrl (
    input  wire logic                     clk_in,
    input  wire logic                     rst_b_in,
    input  wire sram_load_pkg::host_req_s host_req_in,
    output sram_load_pkg::host_ans_s      host_ans_out,
    input  wire sram_load_pkg::fetch_req_s fetch_req_in,
    output sram_load_pkg::fetch_ans_s     fetch_ans_out,
    output logic                          sram_host_access_select_out,
    output logic                          cpu_hold_out,
    output logic                          parity_check_enable_out,
    output logic                          exec_from_sram_out,
    output logic                          parity_bits_select_out,
    output logic                          sram_direction_select_out
);
    import sram_load_pkg::*;

    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    host_ans_s  ans_reg;
    host_ans_s  ans_next;
    fetch_ans_s fetch_reg;
    fetch_ans_s fetch_next;

    logic       wr_ctrl;
    logic       rd_ctrl;
    logic       port_wr;
    logic       port_rd;
    logic       ptr_clr;
    logic       fetch_ok;
    logic [7:0] eng_rdata;
    logic [7:0] eng_fetch_data;
    logic       eng_fetch_parity;

    // ****************************************************************
    // Command decode
    // ****************************************************************
    always_comb begin
        wr_ctrl = host_req_in.valid && host_req_in.write
                  && host_req_in.code == CMD_SRAM_CTRL; // R1
        rd_ctrl = host_req_in.valid && !host_req_in.write
                  && host_req_in.code == CMD_SRAM_CTRL; // R1
        // Blocked data-port reads are still answered with zero; no blocked
        // command touches the SRAM or the pointer.
        port_wr = host_req_in.valid && host_req_in.write
                  && host_req_in.code == CMD_SRAM_DATA
                  && ctrl_reg[BIT_HOST_ACCESS]
                  && !ctrl_reg[BIT_DIRECTION]; // R2 R11
        port_rd = host_req_in.valid && !host_req_in.write
                  && host_req_in.code == CMD_SRAM_DATA
                  && ctrl_reg[BIT_HOST_ACCESS]
                  && ctrl_reg[BIT_DIRECTION]; // R2 R12
        ptr_clr = wr_ctrl && host_req_in.data[BIT_PTR_CLEAR]; // R13
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    // Only reset and a host write change it; core hold is just an output, so the
    // processor reset can never disturb what the host has written.
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next = host_req_in.data; // R1 R4 R5
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ctrl_reg <= CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    always_comb begin
        sram_host_access_select_out = ctrl_reg[BIT_HOST_ACCESS];
        cpu_hold_out                = ctrl_reg[BIT_CORE_HOLD]; // R3
        parity_check_enable_out     = ctrl_reg[BIT_PARITY_EN];
        exec_from_sram_out          = ctrl_reg[BIT_EXEC_SRAM]; // R8
        parity_bits_select_out      = ctrl_reg[BIT_PARITY_SEL];
        sram_direction_select_out   = ctrl_reg[BIT_DIRECTION];
    end

    // ****************************************************************
    // Host answers
    // ****************************************************************
    // Every read is answered one cycle later; unknown codes and blocked
    // data-port reads return zero.
    always_comb begin
        ans_next.valid = host_req_in.valid && !host_req_in.write;
        ans_next.data  = BYTE_ZERO;
        if (rd_ctrl) begin
            ans_next.data = ctrl_reg; // R1
        end else if (port_rd) begin
            ans_next.data = eng_rdata; // R12
        end
    end

    // ****************************************************************
    // Processor fetch from SRAM
    // ****************************************************************
    // A fetch while SRAM execution is off or the core is held returns
    // nothing; the processor then stays on ROM.
    always_comb begin
        fetch_ok = fetch_req_in.valid && ctrl_reg[BIT_EXEC_SRAM]
                   && !ctrl_reg[BIT_CORE_HOLD]; // R3 R8
        fetch_next.valid = fetch_ok;
        fetch_next.data  = fetch_ok ? eng_fetch_data : BYTE_ZERO;
        fetch_next.parity_error = fetch_ok && ctrl_reg[BIT_PARITY_EN]
            && (byte_parity(eng_fetch_data) != eng_fetch_parity); // R6
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ans_reg   <= '0;
            fetch_reg <= '0;
        end else begin
            ans_reg   <= ans_next;
            fetch_reg <= fetch_next;
        end
    end

    always_comb begin
        host_ans_out  = ans_reg;
        fetch_ans_out = fetch_reg;
    end

    // ****************************************************************
    // SRAM and pointer
    // ****************************************************************
    sram_port_engine u_engine (
        .clk_in           (clk_in),
        .rst_b_in         (rst_b_in),
        .port_write_in    (port_wr),
        .port_read_in     (port_rd),
        .parity_sel_in    (ctrl_reg[BIT_PARITY_SEL]), // R10
        .pointer_clear_in (ptr_clr),
        .wdata_in         (host_req_in.data),
        .rdata_out        (eng_rdata),
        .fetch_addr_in    (fetch_req_in.addr),
        .fetch_data_out   (eng_fetch_data),
        .fetch_parity_out (eng_fetch_parity)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    sequence s_ctrl_write;
        host_req_in.valid && host_req_in.write
        && host_req_in.code == CMD_SRAM_CTRL;
    endsequence

    sequence s_data_read_open;
        host_req_in.valid && !host_req_in.write
        && host_req_in.code == CMD_SRAM_DATA
        && sram_host_access_select_out && sram_direction_select_out;
    endsequence

    a_ctrl_write: assert property ( // R1
        s_ctrl_write |=> ctrl_reg == $past(host_req_in.data)
        && ctrl_reg[BIT_RESERVED] == $past(host_req_in.data[BIT_RESERVED]))
        else $error("control write not stored");

    a_ctrl_read: assert property ( // R1
        host_req_in.valid && !host_req_in.write
        && host_req_in.code == CMD_SRAM_CTRL
        |=> host_ans_out.valid && host_ans_out.data == $past(ctrl_reg))
        else $error("control read returned wrong value");

    // A blocked data-port command must leave the pointer where it was and
    // answer zero, whatever the direction bit says.
    a_access_block: assert property ( // R2
        host_req_in.valid && host_req_in.code == CMD_SRAM_DATA
        && !sram_host_access_select_out
        |-> (!port_wr && !port_rd)
        ##1 ($stable(u_engine.ptr_reg)
             && host_ans_out.data == BYTE_ZERO))
        else $error("SRAM reached while host access blocked");

    a_core_hold: assert property ( // R3
        s_ctrl_write ##1 1
        |-> cpu_hold_out == $past(host_req_in.data[BIT_CORE_HOLD]))
        else $error("core hold does not follow control write");

    a_regs_kept: assert property ( // R4
        !wr_ctrl |=> $stable(ctrl_reg))
        else $error("control register changed without host write");

    a_parity_flag: assert property ( // R6
        fetch_ok && byte_parity(eng_fetch_data) != eng_fetch_parity
        |=> fetch_ans_out.parity_error == $past(parity_check_enable_out))
        else $error("parity error flag wrong");

    a_exec_gate: assert property ( // R8
        fetch_req_in.valid && !exec_from_sram_out |=> !fetch_ans_out.valid)
        else $error("SRAM fetch served while execution disabled");

    a_data_write: assert property ( // R11
        host_req_in.valid && host_req_in.write
        && host_req_in.code == CMD_SRAM_DATA
        && sram_host_access_select_out
        |-> port_wr == !sram_direction_select_out)
        else $error("data port write gated wrongly");

    a_data_read: assert property ( // R12
        s_data_read_open |=> host_ans_out.valid
        && host_ans_out.data == $past(eng_rdata))
        else $error("data port read returned wrong value");

endmodule

// *** hdl/sram_port_engine.sv ***
// Program SRAM with its parity bits and the host auto-increment pointer.
`timescale 1ns/1ps
module sram_port_engine (
    input  wire logic                                  clk_in,
    input  wire logic                                  rst_b_in,
    input  wire logic                                  port_write_in,
    input  wire logic                                  port_read_in,
    input  wire logic                                  parity_sel_in,
    input  wire logic                                  pointer_clear_in,
    input  wire logic [7:0]                            wdata_in,
    output logic      [7:0]                            rdata_out,
    input  wire logic [sram_load_pkg::SRAM_ADDR_W-1:0] fetch_addr_in,
    output logic      [7:0]                            fetch_data_out,
    output logic                                       fetch_parity_out
);
    import sram_load_pkg::*;

    logic [7:0]             data_mem   [SRAM_DEPTH];
    logic                   parity_mem [SRAM_DEPTH];
    logic [SRAM_ADDR_W-1:0] ptr_reg;
    logic [SRAM_ADDR_W-1:0] ptr_next;

    // ****************************************************************
    // Pointer
    // ****************************************************************
    // Clear and an access never meet: the host gives one command a cycle.
    always_comb begin
        ptr_next = ptr_reg;
        if (pointer_clear_in) begin
            ptr_next = PTR_ZERO; // R13
        end else if (port_write_in || port_read_in) begin
            ptr_next = ptr_advance(ptr_reg);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ptr_reg <= PTR_ZERO;
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    // ****************************************************************
    // Storage
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (port_write_in && parity_sel_in) begin
            parity_mem[ptr_reg] <= wdata_in[0]; // R10
        end else if (port_write_in) begin
            data_mem[ptr_reg] <= wdata_in; // R11
        end
    end

    always_comb begin
        rdata_out = parity_sel_in ? {7'h00, parity_mem[ptr_reg]}
                                  : data_mem[ptr_reg]; // R10 R12
        fetch_data_out   = data_mem[fetch_addr_in];
        fetch_parity_out = parity_mem[fetch_addr_in];
    end

    a_ptr_clear: assert property ( // R13
        @(posedge clk_in) disable iff (!rst_b_in)
        pointer_clear_in |=> ptr_reg == PTR_ZERO)
        else $error("pointer not returned to zero");

    a_parity_store: assert property ( // R10
        @(posedge clk_in) disable iff (!rst_b_in)
        port_write_in && parity_sel_in |=>
        parity_mem[$past(ptr_reg)] == $past(wdata_in[0]))
        else $error("parity bit not stored at pointer");

    a_ptr_step: assert property ( // R11
        @(posedge clk_in) disable iff (!rst_b_in)
        (port_write_in || port_read_in) && !pointer_clear_in |=>
        ptr_reg == ptr_advance($past(ptr_reg)))
        else $error("pointer did not advance after access");

endmodule

// *** include/sram_load_pkg.sv ***
// Shared constants, types and helpers of the SRAM firmware loader.
package sram_load_pkg;

    // ****************************************************************
    // Command codes and control register layout
    // ****************************************************************
    localparam logic [7:0] CMD_SRAM_CTRL   = 8'h60;
    localparam logic [7:0] CMD_SRAM_DATA   = 8'h61;
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam logic [7:0] BYTE_ZERO       = 8'h00;

    localparam int BIT_HOST_ACCESS = 7;
    localparam int BIT_CORE_HOLD   = 6;
    localparam int BIT_RESERVED    = 5;
    localparam int BIT_PARITY_EN   = 4;
    localparam int BIT_EXEC_SRAM   = 3;
    localparam int BIT_PARITY_SEL  = 2;
    localparam int BIT_DIRECTION   = 1;
    localparam int BIT_PTR_CLEAR   = 0;

    // ****************************************************************
    // Program SRAM geometry
    // ****************************************************************
    localparam int SRAM_ADDR_W = 10;
    localparam int SRAM_DEPTH  = 1024;
    localparam logic [SRAM_ADDR_W-1:0] PTR_ZERO = 10'h000;
    localparam logic [SRAM_ADDR_W-1:0] PTR_STEP = 10'h001;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] code;
        logic [7:0] data;
    } host_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } host_ans_s;

    typedef struct packed {
        logic                   valid;
        logic [SRAM_ADDR_W-1:0] addr;
    } fetch_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       parity_error;
    } fetch_ans_s;

    // Stored parity bit of a byte is the XOR of its eight bits.
    function automatic logic byte_parity(input logic [7:0] b);
        byte_parity = ^b;
    endfunction

    function automatic logic [SRAM_ADDR_W-1:0] ptr_advance(
        input logic [SRAM_ADDR_W-1:0] p);
        ptr_advance = SRAM_ADDR_W'(p + PTR_STEP);
    endfunction

endpackage

// *** testbench/host_model.sv ***
// Host controller model that issues single byte commands to the loader.
`timescale 1ns/1ps
module host_model (
    input  wire logic                     clk_in,
    output sram_load_pkg::host_req_s      req_out,
    input  wire sram_load_pkg::host_ans_s ans_in
);
    import sram_load_pkg::*;

    initial req_out = '0;

    // Idle lines carry the inverse of the last command, so a design that
    // samples outside the valid pulse sees garbage rather than a copy.
    task automatic xfer(input logic w, input logic [7:0] c, d,
                        output logic [7:0] r, output logic v);
        @(posedge clk_in);
        req_out <= '{1'b1, w, c, d};
        @(posedge clk_in);
        req_out <= '{1'b0, ~w, ~c, ~d};
        #1;
        v = ans_in.valid;
        r = ans_in.data;
    endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench of the SRAM loader control block.
`timescale 1ns/1ps
module testbench;
    import sram_load_pkg::*;
    logic        clk_in;
    logic        rst_b_in;
    host_req_s   host_req;
    host_ans_s   host_ans;
    fetch_req_s  fetch_req;
    fetch_ans_s  fetch_ans;
    logic [5:0]  lvl;
    logic [31:0] seed;
    logic [7:0]  r;
    logic        v;
    int          failures;
    int          checked;
    int          ctrl;
    int          ptr;
    int          mem [SRAM_DEPTH];
    int          par [SRAM_DEPTH];

    host_model host (.clk_in(clk_in), .req_out(host_req), .ans_in(host_ans));

    sram_load_ctrl u_sram_load_ctrl (
        .clk_in(clk_in), .rst_b_in(rst_b_in),
        .host_req_in(host_req), .host_ans_out(host_ans),
        .fetch_req_in(fetch_req), .fetch_ans_out(fetch_ans),
        .sram_host_access_select_out(lvl[5]), .cpu_hold_out(lvl[4]),
        .parity_check_enable_out(lvl[3]), .exec_from_sram_out(lvl[2]),
        .parity_bits_select_out(lvl[1]),
        .sram_direction_select_out(lvl[0])
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [9:0] got, exp, input string m);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Model first, then the bus cycle, so expectations never lean on DUT.
    task automatic cmd(input logic w, input logic [7:0] c, d);
        logic       acc;
        logic [7:0] e;
        logic [7:0] k;
        k = 8'(ctrl);
        e = (c == CMD_SRAM_CTRL) ? k : 8'h00;
        acc = (c == CMD_SRAM_DATA) && k[7] && (k[1] != w);
        if (acc && !w)
            e = k[2] ? 8'(par[ptr]) : 8'(mem[ptr]);
        if (acc && w && k[2])
            par[ptr] = int'(d[0]);
        if (acc && w && !k[2])
            mem[ptr] = int'(d);
        if (acc)
            ptr = (ptr + 1) % SRAM_DEPTH;
        if (w && c == CMD_SRAM_CTRL)
            ctrl = int'(d);
        if (w && c == CMD_SRAM_CTRL && d[0])
            ptr = 0;
        host.xfer(w, c, d, r, v);
        chk({1'b0, v, w ? 8'h00 : r},
            {1'b0, !w, w ? 8'h00 : e}, "answer");
        k = 8'(ctrl);
        chk({4'h0, lvl}, {4'h0, k[7:6], k[4:1]}, "levels");
    endtask

    task automatic fetch(input int a);
        logic       go;
        logic [7:0] b;
        b = 8'(mem[a]);
        go = ctrl[3] && !ctrl[6];
        @(posedge clk_in);
        fetch_req <= '{1'b1, 10'(a)};
        @(posedge clk_in);
        fetch_req <= '{1'b0, ~10'(a)};
        #1;
        chk({fetch_ans.valid, fetch_ans.valid ?
             {fetch_ans.data, fetch_ans.parity_error} : 9'h0},
            {go, go ? {b, ctrl[4] && ((^b) != par[a][0])} : 9'h0}, "fetch");
    endtask

    // ****************************************************************
    // Clock, reset, watchdog and sequence
    // ****************************************************************
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        failures++;
        $display("[ERR] %0t run did not finish in time", $time);
        finish_test();
    end

    initial begin
        rst_b_in = 1'b0;
        fetch_req = '0;
        seed = 32'h0000_9917;
        failures = 0;
        checked = 0;
        ctrl = 0;
        ptr = 0;
        repeat (16) @(posedge clk_in);
        rst_b_in <= 1'b1;
        cmd(0, CMD_SRAM_CTRL, 8'h00);
        cmd(0, 8'h7E, 8'h00);
        for (int i = 0; i < 12; i++)
            cmd(1, CMD_SRAM_CTRL, 8'(rnd()));
        cmd(0, CMD_SRAM_CTRL, 8'h00);
        $display("test control register done");
        cmd(1, CMD_SRAM_CTRL, 8'h01);
        cmd(1, CMD_SRAM_DATA, 8'hA5);
        cmd(1, CMD_SRAM_CTRL, 8'h83);
        cmd(1, CMD_SRAM_DATA, 8'h5A);
        cmd(1, CMD_SRAM_CTRL, 8'h81);
        cmd(1, CMD_SRAM_CTRL, 8'h80);
        for (int i = 0; i < 16; i++)
            cmd(1, CMD_SRAM_DATA, 8'(rnd()));
        cmd(1, CMD_SRAM_CTRL, 8'h85);
        for (int i = 0; i < 16; i++)
            cmd(1, CMD_SRAM_DATA, {7'h0, (^mem[i][7:0]) ^ (i == 5)});
        $display("test image load done");
        cmd(1, CMD_SRAM_CTRL, 8'h83);
        for (int i = 0; i < 16; i++)
            cmd(0, CMD_SRAM_DATA, 8'h00);
        cmd(1, CMD_SRAM_CTRL, 8'h02);
        cmd(0, CMD_SRAM_DATA, 8'h00);
        cmd(1, CMD_SRAM_CTRL, 8'h87);
        for (int i = 0; i < 16; i++)
            cmd(0, CMD_SRAM_DATA, 8'h00);
        $display("test read back done");
        cmd(1, CMD_SRAM_CTRL, 8'h18);
        for (int i = 0; i < 16; i++)
            fetch(i);
        cmd(1, CMD_SRAM_CTRL, 8'h08);
        fetch(5);
        cmd(1, CMD_SRAM_CTRL, 8'h10);
        fetch(5);
        cmd(1, CMD_SRAM_CTRL, 8'h58);
        fetch(5);
        cmd(0, CMD_SRAM_CTRL, 8'h00);
        cmd(1, CMD_SRAM_CTRL, 8'hC3);
        cmd(1, CMD_SRAM_CTRL, 8'h82);
        cmd(0, CMD_SRAM_DATA, 8'h00);
        $display("test processor fetch done");
        finish_test();
    end
endmodule
